/* fsp_frame_slot_parser.sv */
// Frame layout and slot property section parser with Avalon-MM registers
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fsp_frame_slot_parser
    import fsp_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic [7:0] SEC_DATA_IN,
    input wire logic SEC_VALID_IN,
    input wire logic SEC_START_IN,
    output logic SEC_READY_OUT,
    output logic FRAME_VALID_OUT,
    output fsp_frame_t FRAME_OUT,
    output logic SLOT_VALID_OUT,
    output fsp_slot_t SLOT_OUT,
    output logic PROP_VALID_OUT,
    output fsp_prop_t PROP_OUT,
    output logic SEC_DONE_OUT,
    output logic SEC_OK_OUT,
    input wire logic [4:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT
);
    fsp_pars_t st_q, st_d;
    logic acc;
    logic last;
    logic [31:0] sh;
    logic stage_we;
    logic commit;
    logic clear;
    logic [23:0] live_dur [256];
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] ctrl_q, ctrl_d;
    logic err_q, err_d;
    logic [31:0] okcnt_q, okcnt_d;
    logic [31:0] errcnt_q, errcnt_d;
    logic errclr;

    // Section check register advanced by one byte, MSB first
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[31] ^ b[i]) ? ({r[30:0], 1'b0} ^ CRC_POLY) : {r[30:0], 1'b0};
        end
        return r;
    endfunction

    // Move to the next entry or to the section tail
    function automatic fsp_pars_t next_entry(input fsp_pars_t s);
        fsp_pars_t n;
        n = s;
        if (s.ent_left == 8'h00) begin
            n.state = S_TAIL;
        end else begin
            n.ent_left = s.ent_left - 8'h01;
            n.state = s.tbl ? S_PROP : S_ENT;
            n.pos = '0;
        end
        return n;
    endfunction

    assign acc = SEC_VALID_IN && st_q.ready;
    assign sh = {st_q.acc[23:0], SEC_DATA_IN};
    assign last = (st_q.state != S_IDLE) && (st_q.state != S_HDR)
                  && (st_q.idx == st_q.len + LAST_OFS);

    // Parser next state
    always_comb begin
        st_d = st_q;
        st_d.frm_vld = 1'b0;
        st_d.slot_vld = 1'b0;
        st_d.prop_vld = 1'b0;
        st_d.done = 1'b0;
        stage_we = 1'b0;
        commit = 1'b0;
        clear = 1'b0;
        if (st_q.state == S_EXP) begin
            // One slot per cycle while the input is held off
            st_d.slot_vld = 1'b1;
            st_d.slot = '{frame: st_q.frm.label, num: st_q.num, type_label: st_q.type_label,
                          freq: st_q.freq, time_ofs: st_q.time_cur, first: st_q.first};
            st_d.slot_dur = live_dur[st_q.type_label];
            st_d.time_cur = st_q.time_cur + 32'(live_dur[st_q.type_label]);
            st_d.num = st_q.num + 11'h001;
            st_d.first = 1'b0;
            if (st_q.rep_left != 8'h00) begin
                st_d.rep_left = st_q.rep_left - 8'h01;
            end else if (st_q.grp_left != 8'h00) begin
                st_d.grp_left = st_q.grp_left - 8'h01;
                st_d.state = S_GRP;
                st_d.pos = '0;
            end else begin
                st_d = next_entry(st_d);
            end
        end else if (acc) begin
            st_d.acc = sh;
            st_d.idx = st_q.idx + 12'h001;
            st_d.crc = crc_byte(st_q.crc, SEC_DATA_IN);
            st_d.pos = st_q.pos + 4'h1;
            if (SEC_START_IN) begin
                st_d.state = ctrl_q[CTRL_EN_BIT] ? S_HDR : S_IDLE;
                st_d.idx = 12'h001;
                st_d.crc = crc_byte(CRC_INIT, SEC_DATA_IN);
                st_d.tbl = ctrl_q[CTRL_TBL_BIT];
                clear = 1'b1;
            end else begin
                case (st_q.state)
                    S_HDR: begin
                        if (st_q.idx == HDR_LEN_IDX) begin
                            st_d.len = sh[11:0];
                        end
                        if (st_q.idx == HDR_LAST_IDX) begin
                            st_d.state = S_CNT;
                        end
                    end
                    S_CNT: begin
                        st_d.ent_left = SEC_DATA_IN;
                        st_d.state = st_q.tbl ? S_PROP : S_ENT;
                        st_d.pos = '0;
                    end
                    S_ENT: begin
                        case (st_q.pos)
                            E_LABEL_POS: st_d.frm.label = SEC_DATA_IN;
                            E_LEN_POS: st_d.frm.length = sh;
                            E_TOTAL_POS: st_d.frm.total = sh[10:0];
                            E_FIRST_POS: begin
                                st_d.frm.first = sh[10:0];
                                st_d.num = sh[10:0];
                            end
                            E_GRPS_POS: begin
                                st_d.frm.groups = SEC_DATA_IN;
                                st_d.grp_left = SEC_DATA_IN;
                                st_d.frm_vld = 1'b1;
                                st_d.state = S_GRP;
                                st_d.pos = '0;
                            end
                            default: ;
                        endcase
                    end
                    S_GRP: begin
                        case (st_q.pos)
                            G_FREQ_POS: st_d.freq = sh[23:0];
                            G_TIME_POS: st_d.time_cur = sh;
                            G_TYPE_POS: st_d.type_label = SEC_DATA_IN;
                            G_REP_POS: begin
                                st_d.rep_left = SEC_DATA_IN;
                                st_d.first = 1'b1;
                                st_d.state = S_EXP;
                            end
                            default: ;
                        endcase
                    end
                    S_PROP: begin
                        case (st_q.pos)
                            P_LABEL_POS: begin
                                st_d.prop = '0;
                                st_d.prop.label = SEC_DATA_IN;
                            end
                            P_DUR_POS: st_d.prop.duration = sh[23:0];
                            P_CODE_POS: st_d.prop.code_type = SEC_DATA_IN[P_CODE_TYPE_BIT];
                            P_FLAGS_POS: begin
                                st_d.prop.new_perm = SEC_DATA_IN[P_NEW_PERM_BIT];
                                st_d.state = (st_q.prop.code_type
                                              && SEC_DATA_IN[P_NEW_PERM_BIT]) ? S_PERM : S_PLEN;
                                st_d.pos = '0;
                            end
                            default: ;
                        endcase
                    end
                    S_PERM: begin
                        case (st_q.pos)
                            Q_A_POS: st_d.prop.interleave_param_a = sh[4:0];
                            Q_B_POS: st_d.prop.interleave_param_b = sh[9:0];
                            Q_C_POS: st_d.prop.interleave_param_c = sh[9:0];
                            Q_D_POS: begin
                                st_d.prop.interleave_param_d = sh[9:0];
                                st_d.state = S_PLEN;
                            end
                            default: ;
                        endcase
                    end
                    S_PLEN: begin
                        st_d.prop_vld = 1'b1;
                        stage_we = 1'b1;
                        st_d.skip = 7'((9'(SEC_DATA_IN) + 9'h003) >> 2);
                        if (SEC_DATA_IN == 8'h00) begin
                            st_d = next_entry(st_d);
                        end else begin
                            st_d.state = S_PSKIP;
                        end
                    end
                    S_PSKIP: begin
                        st_d.skip = st_q.skip - 7'h01;
                        if (st_q.skip == 7'h01) begin
                            st_d = next_entry(st_d);
                        end
                    end
                    default: ;
                endcase
                if (last) begin
                    // Accept only a complete section with zero residue
                    st_d.state = S_IDLE;
                    st_d.done = 1'b1;
                    st_d.ok = (st_d.crc == 32'h00000000) && (st_q.state == S_TAIL);
                    commit = st_d.ok;
                    clear = 1'b1;
                end
            end
        end
        st_d.ready = (st_d.state != S_EXP);
    end

    // Parser registers
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            st_q <= PARS_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Slot durations, staged per section and made live on a good check
    for (genvar g = 0; g < 256; g++) begin : g_dur
        logic [23:0] live_q, live_d, stg_q, stg_d;
        logic mk_q, mk_d;
        always_comb begin
            live_d = live_q;
            stg_d = stg_q;
            mk_d = mk_q;
            if (stage_we && (st_q.prop.label == 8'(g))) begin
                stg_d = st_q.prop.duration;
                mk_d = 1'b1;
            end
            if (commit && mk_q) begin
                live_d = stg_q;
            end
            if (clear) begin
                mk_d = 1'b0;
            end
        end
        always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
            if (RST_IN) begin
                live_q <= '0;
                stg_q <= '0;
                mk_q <= 1'b0;
            end else begin
                live_q <= live_d;
                stg_q <= stg_d;
                mk_q <= mk_d;
            end
        end
        assign live_dur[g] = live_q;
    end

    // Avalon-MM slave: one wait cycle, then the answer
    always_comb begin
        wait_d = 1'b1;
        rdata_d = rdata_q;
        ctrl_d = ctrl_q;
        errclr = 1'b0;
        if ((AVS_READ_IN || AVS_WRITE_IN) && wait_q) begin
            wait_d = 1'b0;
            if (AVS_READ_IN) begin
                case (AVS_ADDRESS_IN)
                    REG_CTRL: rdata_d = {30'h0, ctrl_q};
                    REG_STATUS: rdata_d = {29'h0, err_q, st_q.ok, st_q.state != S_IDLE};
                    REG_OK_CNT: rdata_d = okcnt_q;
                    REG_ERR_CNT: rdata_d = errcnt_q;
                    REG_LAST: rdata_d = {13'h0, st_q.frm.total, st_q.frm.label};
                    default: rdata_d = 32'h00000000;
                endcase
            end
        end
        if (AVS_WRITE_IN && !wait_q && AVS_BYTEENABLE_IN[0]) begin
            if (AVS_ADDRESS_IN == REG_CTRL) begin
                ctrl_d = AVS_WRITEDATA_IN[1:0];
            end
            errclr = (AVS_ADDRESS_IN == REG_STATUS) && AVS_WRITEDATA_IN[STAT_ERR_BIT];
        end
        // Hardware set wins over software clear
        err_d = (err_q && !errclr) || (st_q.done && !st_q.ok);
        okcnt_d = okcnt_q + 32'((st_q.done && st_q.ok) ? 1 : 0);
        errcnt_d = errcnt_q + 32'((st_q.done && !st_q.ok) ? 1 : 0);
    end

    // Bus registers
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
            ctrl_q <= CTRL_RST;
            err_q <= 1'b0;
            okcnt_q <= '0;
            errcnt_q <= '0;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            err_q <= err_d;
            okcnt_q <= okcnt_d;
            errcnt_q <= errcnt_d;
        end
    end

    assign SEC_READY_OUT = st_q.ready;
    assign FRAME_VALID_OUT = st_q.frm_vld;
    assign FRAME_OUT = st_q.frm;
    assign SLOT_VALID_OUT = st_q.slot_vld;
    assign SLOT_OUT = st_q.slot;
    assign PROP_VALID_OUT = st_q.prop_vld;
    assign PROP_OUT = st_q.prop;
    assign SEC_DONE_OUT = st_q.done;
    assign SEC_OK_OUT = st_q.ok;
    assign AVS_READDATA_OUT = rdata_q;
    assign AVS_WAITREQUEST_OUT = wait_q;

    // Checks on the parser and bus
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);
    sequence s_grp_end;
        st_q.state == S_GRP && acc && !SEC_START_IN && st_q.pos == G_REP_POS && !last;
    endsequence
    property p_exp_stall;
        s_grp_end |=> st_q.state == S_EXP && !SEC_READY_OUT;
    endproperty
    a_exp_stall: assert property (p_exp_stall) else $error("input not held off");
    property p_rep_one;
        s_grp_end ##0 SEC_DATA_IN == 8'h00 |=> ##1 SLOT_VALID_OUT ##1 !SLOT_VALID_OUT;
    endproperty
    a_rep_one: assert property (p_rep_one) else $error("repeat zero not one slot");
    property p_rep_three;
        s_grp_end ##0 SEC_DATA_IN == 8'h02 |=> ##1 SLOT_VALID_OUT[*3] ##1 !SLOT_VALID_OUT;
    endproperty
    a_rep_three: assert property (p_rep_three) else $error("repeat two not three");
    property p_time;
        SLOT_VALID_OUT && !SLOT_OUT.first
            |-> SLOT_OUT.time_ofs == 32'($past(SLOT_OUT.time_ofs) + $past(st_q.slot_dur));
    endproperty
    a_time: assert property (p_time) else $error("repeat time offset wrong");
    property p_freq;
        SLOT_VALID_OUT && !SLOT_OUT.first |-> SLOT_OUT.freq == $past(SLOT_OUT.freq);
    endproperty
    a_freq: assert property (p_freq) else $error("repeat frequency changed");
    property p_num;
        SLOT_VALID_OUT && $past(SLOT_VALID_OUT) |-> SLOT_OUT.num == 11'($past(SLOT_OUT.num) + 1);
    endproperty
    a_num: assert property (p_num) else $error("slot number not consecutive");
    property p_hdr;
        st_q.state == S_CNT && acc && !SEC_START_IN |-> st_q.idx == 12'h008;
    endproperty
    a_hdr: assert property (p_hdr) else $error("header not eight bytes");
    property p_perm;
        PROP_VALID_OUT && !(PROP_OUT.code_type && PROP_OUT.new_perm)
            |-> PROP_OUT.interleave_param_a == 5'h00 && PROP_OUT.interleave_param_d == 10'h000;
    endproperty
    a_perm: assert property (p_perm) else $error("interleave parameters without flags");
    property p_ok;
        SEC_DONE_OUT && SEC_OK_OUT |-> $past(st_q.state) == S_TAIL;
    endproperty
    a_ok: assert property (p_ok) else $error("incomplete section accepted");
    property p_errcnt;
        SEC_DONE_OUT && !SEC_OK_OUT |=> errcnt_q == 32'($past(errcnt_q) + 1) && err_q;
    endproperty
    a_errcnt: assert property (p_errcnt) else $error("failed section not flagged");
    property p_wait;
        (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");
endmodule // fsp_frame_slot_parser
`default_nettype wire

/* fsp_pkg.sv */
// Constants, types and register map of the frame and slot table parser
`default_nettype none
package fsp_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h04;
    localparam logic [4:0] REG_OK_CNT = 5'h08;
    localparam logic [4:0] REG_ERR_CNT = 5'h0c;
    localparam logic [4:0] REG_LAST = 5'h10;
    // Control and status field positions and reset values
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_TBL_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_OK_BIT = 1;
    localparam int STAT_ERR_BIT = 2;
    localparam logic [1:0] CTRL_RST = 2'h1;
    // Section layout in bytes
    localparam logic [11:0] HDR_LEN_IDX = 12'h002;
    localparam logic [11:0] HDR_LAST_IDX = 12'h007;
    localparam logic [11:0] LAST_OFS = 12'h002;
    // Byte positions inside a frame entry
    localparam logic [3:0] E_LABEL_POS = 4'h0;
    localparam logic [3:0] E_LEN_POS = 4'h4;
    localparam logic [3:0] E_TOTAL_POS = 4'h6;
    localparam logic [3:0] E_FIRST_POS = 4'h8;
    localparam logic [3:0] E_GRPS_POS = 4'h9;
    // Byte positions inside a slot group
    localparam logic [3:0] G_FREQ_POS = 4'h2;
    localparam logic [3:0] G_TIME_POS = 4'h6;
    localparam logic [3:0] G_TYPE_POS = 4'h7;
    localparam logic [3:0] G_REP_POS = 4'h8;
    // Byte positions inside a slot property entry
    localparam logic [3:0] P_LABEL_POS = 4'h0;
    localparam logic [3:0] P_DUR_POS = 4'h6;
    localparam logic [3:0] P_CODE_POS = 4'h9;
    localparam logic [3:0] P_FLAGS_POS = 4'hd;
    localparam int P_CODE_TYPE_BIT = 7;
    localparam int P_NEW_PERM_BIT = 0;
    // Byte positions of the interleave parameters
    localparam logic [3:0] Q_A_POS = 4'h0;
    localparam logic [3:0] Q_B_POS = 4'h2;
    localparam logic [3:0] Q_C_POS = 4'h4;
    localparam logic [3:0] Q_D_POS = 4'h6;
    // Section check polynomial and start value
    localparam logic [31:0] CRC_POLY = 32'h04c11db7;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;

    typedef enum logic [10:0] {
        S_IDLE = 11'h001,
        S_HDR = 11'h002,
        S_CNT = 11'h004,
        S_ENT = 11'h008,
        S_GRP = 11'h010,
        S_EXP = 11'h020,
        S_PROP = 11'h040,
        S_PERM = 11'h080,
        S_PLEN = 11'h100,
        S_PSKIP = 11'h200,
        S_TAIL = 11'h400
    } fsp_state_t;

    typedef struct packed {
        logic [7:0] label;
        logic [31:0] length;
        logic [10:0] total;
        logic [10:0] first;
        logic [7:0] groups;
    } fsp_frame_t;

    typedef struct packed {
        logic [7:0] frame;
        logic [10:0] num;
        logic [7:0] type_label;
        logic [23:0] freq;
        logic [31:0] time_ofs;
        logic first;
    } fsp_slot_t;

    typedef struct packed {
        logic [7:0] label;
        logic [23:0] duration;
        logic code_type;
        logic new_perm;
        logic [4:0] interleave_param_a;
        logic [9:0] interleave_param_b;
        logic [9:0] interleave_param_c;
        logic [9:0] interleave_param_d;
    } fsp_prop_t;

    typedef struct packed {
        fsp_state_t state;
        logic [3:0] pos;
        logic [11:0] idx;
        logic [11:0] len;
        logic [31:0] acc;
        logic [31:0] crc;
        logic tbl;
        logic [7:0] ent_left;
        logic [7:0] grp_left;
        logic [7:0] rep_left;
        logic [6:0] skip;
        logic [10:0] num;
        logic [31:0] time_cur;
        logic [23:0] freq;
        logic [7:0] type_label;
        logic first;
        fsp_frame_t frm;
        fsp_prop_t prop;
        fsp_slot_t slot;
        logic [23:0] slot_dur;
        logic ready;
        logic frm_vld;
        logic slot_vld;
        logic prop_vld;
        logic done;
        logic ok;
    } fsp_pars_t;

    localparam fsp_pars_t PARS_RST = '{state: S_IDLE, crc: CRC_INIT, ready: 1'b1,
                                       default: '0};
endpackage
`default_nettype wire

/* fsp_sec_src.sv */
// Section byte source standing in for the demultiplexer
`timescale 1ns/100ps
`default_nettype none
module fsp_sec_src (
    input wire logic clk_in,
    input wire logic rdy_in,
    output logic [7:0] data_out,
    output logic vld_out,
    output logic start_out
);
    // Released lines show the inverse of the last byte
    task automatic idle();
        vld_out <= 1'b0;
        start_out <= 1'b0;
        data_out <= ~data_out;
    endtask
    // One byte, held until taken, with an optional stall
    task automatic put(input logic [7:0] b, input logic first, input logic gap);
        if (gap) begin
            idle();
            @(posedge clk_in);
        end
        data_out <= b;
        start_out <= first;
        vld_out <= 1'b1;
        do @(posedge clk_in); while (rdy_in !== 1'b1);
    endtask
    // Quiet at time zero
    initial begin
        data_out = 8'h00;
        vld_out = 1'b0;
        start_out = 1'b0;
    end
endmodule // fsp_sec_src
`default_nettype wire

/* testbench.sv */
// Self-checking bench of the frame and slot table parser
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) chk(128'(a), 128'(e))
module testbench;
    import fsp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic rdy, wq, fv, sv, pv, dn, ok, vld, st, okq[$];
    logic [7:0] dat, s[$];
    logic [4:0] adr = 5'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    fsp_frame_t fo, lf, fq[$];
    fsp_slot_t so, sq[$];
    fsp_prop_t po, pa, pe, pq[$];
    logic [23:0] dur[256] = '{default: 24'h0}, stg[256] = '{default: 24'h0};
    int n_mismatch = 0, samples_checked = 0;
    // Clock
    always #20 clk = ~clk;
    fsp_frame_slot_parser dut (.REF_CLK_IN(clk), .RST_IN(rst), .SEC_DATA_IN(dat),
        .SEC_VALID_IN(vld), .SEC_START_IN(st), .SEC_READY_OUT(rdy), .FRAME_VALID_OUT(fv),
        .FRAME_OUT(fo), .SLOT_VALID_OUT(sv), .SLOT_OUT(so), .PROP_VALID_OUT(pv),
        .PROP_OUT(po), .SEC_DONE_OUT(dn), .SEC_OK_OUT(ok), .AVS_ADDRESS_IN(adr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
        .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wq));
    fsp_sec_src src (.clk_in(clk), .rdy_in(rdy), .data_out(dat), .vld_out(vld), .start_out(st));
    // One comparison
    task automatic chk(input logic [127:0] a, input logic [127:0] e);
        samples_checked++;
        if (a !== e) begin
            n_mismatch++;
            $display("ERROR %0t: got %h want %h", $time, a, e);
        end
    endtask
    // Counts and verdict
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Register access, held until waitrequest drops
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 100);
        if (wq !== 1'b0) begin
            n_mismatch++;
            $display("ERROR %0t: bus timeout", $time);
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // Pushes n bytes, most significant first
    task automatic pb(input logic [31:0] v, input int n);
        for (int k = n - 1; k >= 0; k--) s.push_back(v[8 * k +: 8]);
    endtask
    // Section header with random filler
    task automatic hdr(input logic [7:0] tid);
        s = {tid, 8'h00, 8'h00};
        repeat (5) s.push_back(8'($urandom));
    endtask
    // Fills length, appends check word, optionally corrupted, and sends
    task automatic fin_send(input logic bad);
        logic [31:0] c;
        logic [11:0] n;
        n = 12'(s.size() + 1);
        s[1] = {4'hb, n[11:8]};
        s[2] = n[7:0];
        c = CRC_INIT;
        foreach (s[i])
            for (int k = 7; k >= 0; k--)
                c = {c[30:0], 1'b0} ^ ((c[31] ^ s[i][k]) ? CRC_POLY : 32'h0);
        pb(c ^ {31'h0, bad}, 4);
        okq.push_back(!bad);
        foreach (s[i]) src.put(s[i], i == 0, $urandom_range(3) == 0);
        src.idle();
    endtask
    // Slot property section, first entry with interleave parameters
    task automatic props(input logic bad);
        fsp_prop_t p;
        hdr(8'hb1);
        pb(1, 1);
        for (int e = 0; e < 2; e++) begin
            p = 69'({$urandom, $urandom, $urandom});
            p.label = 8'(e * 7 + 1);
            p.code_type = 1'b1;
            p.new_perm = (e == 0);
            pb({p.label, 24'($urandom)}, 4);
            pb({p.duration, 8'($urandom)}, 4);
            pb({8'($urandom), p.code_type, 7'($urandom)}, 2);
            pb({24'($urandom), 7'($urandom), p.new_perm}, 4);
            if (p.new_perm) pb({3'h7, p.interleave_param_a, 6'h3f, p.interleave_param_b}, 3);
            if (p.new_perm) pb({6'h3f, p.interleave_param_c, 6'h3f, p.interleave_param_d}, 4);
            pb(32'h0005abcd, 3);
            pq.push_back(p);
            stg[p.label] = p.duration;
        end
        fin_send(bad);
        if (!bad) dur = stg;
    endtask
    // Frame layout section and the slots it expands to
    task automatic frames(input int ne, input logic bad);
        fsp_slot_t l;
        logic [7:0] rep;
        hdr(8'hb0);
        pb(ne - 1, 1);
        repeat (ne) begin
            {lf.label, lf.length, lf.total, lf.first} = 62'({$urandom, $urandom});
            lf.groups = 8'($urandom_range(2));
            pb(32'(lf.label), 1);
            pb(lf.length, 4);
            pb({5'h1f, lf.total, 5'h1f, lf.first}, 4);
            pb(lf.groups, 1);
            fq.push_back(lf);
            l = '0;
            l.frame = lf.label;
            l.num = lf.first;
            repeat (lf.groups + 1) begin
                {l.freq, l.time_ofs} = 56'({$urandom, $urandom});
                l.type_label = 8'($urandom_range(2) * 7 + 1);
                rep = (dur[l.type_label] == 24'h0) ? 8'h00 : 8'($urandom_range(2));
                pb({l.freq, l.time_ofs[31:24]}, 4);
                pb({l.time_ofs[23:0], l.type_label}, 4);
                pb(rep, 1);
                for (int r = 0; r <= rep; r++) begin
                    l.first = (r == 0);
                    sq.push_back(l);
                    l.time_ofs += dur[l.type_label];
                    l.num++;
                end
            end
        end
        fin_send(bad);
    endtask
    // Model comparison at every result pulse
    always @(posedge clk) begin
        if (fv === 1'b1) `CHK(fo, fq.pop_front());
        if (sv === 1'b1) `CHK(so, sq.pop_front());
        if (dn === 1'b1) `CHK(ok, okq.pop_front());
        if (pv === 1'b1) begin
            pe = pq.pop_front();
            pa = po;
            if (!pe.new_perm) {pa[34:0], pe[34:0]} = 70'h0;
            `CHK(pa, pe);
        end
    end
    // Main sequence
    initial begin
        void'($urandom(71));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, REG_CTRL, 32'h0);
        `CHK(q, 32'h1);
        bus(1'b0, 5'h14, 32'h0);
        `CHK(q, 32'h0);
        for (int t = 0; t < 5; t++) begin
            bus(1'b1, REG_CTRL, {30'h0, t < 2, 1'b1});
            if (t < 2) props(t == 1);
            else frames((t == 3) ? 3 : 1, t == 4);
            repeat (30) @(posedge clk);
            $display("test %0d done", t);
        end
        bus(1'b0, REG_LAST, 32'h0);
        `CHK(q, {13'h0, lf.total, lf.label});
        bus(1'b0, REG_OK_CNT, 32'h0);
        `CHK(q, 32'h3);
        bus(1'b0, REG_ERR_CNT, 32'h0);
        `CHK(q, 32'h2);
        bus(1'b0, REG_STATUS, 32'h0);
        `CHK(q, 32'h4);
        bus(1'b1, REG_STATUS, 32'h4);
        bus(1'b0, REG_STATUS, 32'h0);
        `CHK(q, 32'h0);
        `CHK(fq.size() + sq.size() + pq.size() + okq.size(), 0);
        summarize();
    end
    // Watchdog
    initial begin
        #2000000;
        n_mismatch++;
        $display("ERROR %0t: watchdog expired", $time);
        summarize();
    end
endmodule // testbench
`default_nettype wire
